// ---- rtl/sdbc_core.sv ----
// Storage discharge sequencer and isolation switch controller
`timescale 1ns/1ps
// Operation
// - Storage good only above programmed fraction
// - Threshold field decodes 90.5 or 94.5 base
// - Auto sink on entering reset state
// - Software write starts discharge, bit self-clears
// - Low pin starts discharge when enabled
// - Discharge opens eFuse and stops buck and boost
// - Stop buck, then boost and switch, then sink
// - Done bit set below ten milliamp
// - After discharge clear bit, reset, restart
// - Discharge ignores input recovery until done
// - Sinks only with auto enable; stages off
// - Forced off latches; discharge exits on rails
// - Soft start charges until switch settled
// - Then switch fully on, 2A limit
// - 250ms timeout, 250ms off, retry
// - Retry-once option goes to supplement-disable
// - 2A overcurrent trips, flags, retries
// - Hiccup keeps eFuse on, supplement-disable
// - Manual switch control when option set
// - Switch off forces boost off
// - Supplement state enables storage buck
module sdbc_core #(
    parameter int TICK_CYCLES = sdbc_pkg::SDBC_TICK_CYCLES,
    parameter int RETRY_TICKS = sdbc_pkg::SDBC_RETRY_TICKS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog sense
    input wire sdbc_pkg::sdbc_sense_t sense,
    input wire logic [9:0] storage_pct,
    input wire logic discharge_pin_n,
    // Outputs
    output sdbc_pkg::sdbc_drive_t drive,
    output logic storage_pg,
    output logic split_node_fault,
    output logic interrupt_out_n
);
    import sdbc_pkg::*;

    sdbc_state_t state, next_state;
    logic [7:0] cfg, next_cfg, opt, next_opt;
    logic sw_on, next_sw_on, dis_all, next_dis_all, gpio_en, next_gpio_en;
    logic done, next_done, tried, next_tried, uv_flag, next_uv_flag;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [15:0] ms_cnt, next_ms_cnt;
    logic tick, start_dis, timeout, sinks_ok;
    logic [9:0] pg_thr;
    sdbc_drive_t next_drive;
    logic next_pg;

    assign pg_thr = (cfg[3] ? SDBC_PG_BASE_HI : SDBC_PG_BASE_LO)
        + SDBC_PG_STEP * {7'h00, cfg[2:0]};
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    assign timeout = (ms_cnt >= 16'(RETRY_TICKS));
    assign sinks_ok = cfg[SDBC_BIT_AUTO_SINK];
    assign start_dis = dis_all || (gpio_en && !discharge_pin_n);
    assign interrupt_out_n = !uv_flag;

    always_comb begin
        reg_rdata = 8'h00;
        unique case (reg_addr)
            SDBC_REG_DISCHARGE_CONFIG: reg_rdata = cfg;
            SDBC_REG_ISO_OPTIONS: reg_rdata = opt;
            SDBC_REG_DIS_SW_CONTROL: reg_rdata = {4'h0, done, gpio_en,
                dis_all, sw_on};
            default: reg_rdata = 8'h00;
        endcase
    end

    always_comb begin
        next_cfg = cfg;
        next_opt = opt;
        next_sw_on = sw_on;
        next_dis_all = dis_all;
        next_gpio_en = gpio_en;
        next_done = done;
        next_uv_flag = uv_flag;
        next_tried = tried;
        next_state = state;
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
        next_ms_cnt = (tick && !timeout) ? ms_cnt + 16'h1 : ms_cnt;
        if (reg_wr) begin
            if (reg_addr == SDBC_REG_DISCHARGE_CONFIG) next_cfg = reg_wdata;
            if (reg_addr == SDBC_REG_ISO_OPTIONS) next_opt = reg_wdata;
            if (reg_addr == SDBC_REG_DIS_SW_CONTROL) begin
                next_sw_on = reg_wdata[SDBC_BIT_SWITCH_ON];
                if (reg_wdata[SDBC_BIT_DISCHARGE_ALL]) next_dis_all = 1'b1;
                next_gpio_en = reg_wdata[SDBC_BIT_GPIO_DIS_EN];
                if (reg_wdata[SDBC_BIT_DONE]) next_done = 1'b0;
            end
        end
        unique case (state)
            SDBC_POR: begin
                next_ms_cnt = 16'h0;
                if (sense.vin_ok && !start_dis) begin
                    next_state = SDBC_SOFT;
                    next_tried = 1'b0;
                end
            end
            SDBC_SOFT: begin
                if (sense.switch_settled && sense.storage_at_vin) begin
                    next_state = SDBC_ON;
                end else if (timeout) begin
                    next_ms_cnt = 16'h0;
                    next_tried = 1'b1;
                    next_state = opt[SDBC_BIT_RETRY_ONCE] ? SDBC_SUPP_DIS
                        : SDBC_HICCUP;
                end
            end
            SDBC_ON: begin
                if (sense.overcurrent) begin
                    next_uv_flag = 1'b1;
                    next_ms_cnt = 16'h0;
                    next_state = SDBC_HICCUP;
                end else if (sense.power_fail) begin
                    next_state = SDBC_SUPP;
                end
            end
            SDBC_HICCUP: if (timeout) begin
                next_ms_cnt = 16'h0;
                next_state = sense.overcurrent ? SDBC_HICCUP : SDBC_SOFT;
            end
            SDBC_SUPP: if (!sense.vin_ok && !sense.str_ok) begin
                next_state = SDBC_POR;
            end
            SDBC_SUPP_DIS: if (!sense.vin_ok) next_state = SDBC_POR;
            SDBC_DIS_STOP: next_state = SDBC_DIS_OPEN;
            SDBC_DIS_OPEN: next_state = SDBC_DIS_SINK;
            SDBC_DIS_SINK: begin
                if (sense.sink_below_10ma || !sinks_ok) next_done = 1'b1;
                if (!sense.bus_ok && (!sinks_ok || !sense.str_ok)
                    && (next_done || done)) begin
                    next_dis_all = 1'b0;
                    next_state = SDBC_POR;
                end
            end
            SDBC_FORCED: if (!sense.bus_ok && !sense.str_ok && !sense.vin_ok)
                next_state = SDBC_POR;
            default: next_state = SDBC_POR;
        endcase
        if (sense.overcurrent && state == SDBC_SOFT) begin
            next_uv_flag = 1'b1;
            next_ms_cnt = 16'h0;
            next_state = SDBC_HICCUP;
        end
        if (sense.forced_shutdown && state != SDBC_FORCED)
            next_state = SDBC_FORCED;
        else if (start_dis && state inside {SDBC_SOFT, SDBC_ON, SDBC_HICCUP,
            SDBC_SUPP, SDBC_SUPP_DIS})
            next_state = SDBC_DIS_STOP;
        // Register write of 1 clears the latched fault
        if (reg_wr && reg_addr == SDBC_REG_ISO_OPTIONS && reg_wdata[7])
            next_uv_flag = 1'b0;
        if (sense.overcurrent) next_uv_flag = 1'b1;
    end

    always_comb begin
        next_drive = '0;
        unique case (state)
            SDBC_POR: next_drive.rail_sink_on = sinks_ok && !sense.vin_ok;
            SDBC_SOFT: begin
                next_drive.efuse_on = 1'b1;
                next_drive.isolation_switch_on = 1'b1;
                next_drive.soft_current = 1'b1;
            end
            SDBC_ON: begin
                next_drive.efuse_on = 1'b1;
                next_drive.isolation_switch_on = 1'b1;
                next_drive.boost_on = 1'b1;
                next_drive.limit_2a = 1'b1;
            end
            SDBC_HICCUP, SDBC_SUPP_DIS: next_drive.efuse_on = 1'b1;
            SDBC_SUPP: begin
                next_drive.buck_on = 1'b1;
                next_drive.isolation_switch_on = 1'b1;
            end
            SDBC_DIS_STOP: begin
                next_drive.boost_on = drive.boost_on;
                next_drive.isolation_switch_on = drive.isolation_switch_on;
            end
            SDBC_DIS_OPEN: next_drive.isolation_switch_on = 1'b0;
            SDBC_DIS_SINK, SDBC_FORCED: next_drive.rail_sink_on = sinks_ok;
            default: next_drive = '0;
        endcase
        if (opt[SDBC_BIT_MANUAL] && state inside {SDBC_SOFT, SDBC_ON})
            next_drive.isolation_switch_on = sw_on;
        if (!next_drive.isolation_switch_on) next_drive.boost_on = 1'b0;
        next_pg = storage_pct > pg_thr;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= SDBC_POR;
            cfg <= SDBC_RST_DISCHARGE_CONFIG;
            opt <= SDBC_RST_ISO_OPTIONS;
            {sw_on, dis_all, gpio_en, done} <= 4'h0;
            tried <= 1'b0;
            uv_flag <= 1'b0;
            tick_cnt <= 32'h0;
            ms_cnt <= 16'h0;
            drive <= '0;
            storage_pg <= 1'b0;
            split_node_fault <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            opt <= next_opt;
            sw_on <= next_sw_on;
            dis_all <= next_dis_all;
            gpio_en <= next_gpio_en;
            done <= next_done;
            tried <= next_tried;
            uv_flag <= next_uv_flag;
            tick_cnt <= next_tick_cnt;
            ms_cnt <= next_ms_cnt;
            drive <= next_drive;
            storage_pg <= next_pg;
            split_node_fault <= next_uv_flag;
        end
    end

    // Discharge steps, one state per cycle
    sequence s_dis_open;
        state == SDBC_DIS_OPEN;
    endsequence
    sequence s_dis_sink;
        state == SDBC_DIS_SINK;
    endsequence
    // Trip steps: hiccup first, switch drops a cycle later
    sequence s_trip_hiccup;
        state == SDBC_HICCUP;
    endsequence
    sequence s_switch_dropped;
        !drive.isolation_switch_on;
    endsequence

    chk_pg_follows_compare: assert property (@(posedge clk_sys)
        disable iff (rst) storage_pg == $past(storage_pct > pg_thr))
        else $error("storage good mismatch");
    chk_discharge_order: assert property (@(posedge clk_sys)
        disable iff (rst) state == SDBC_DIS_STOP
        |=> s_dis_open ##1 s_dis_sink)
        else $error("discharge order broken");
    chk_boost_with_switch: assert property (@(posedge clk_sys)
        disable iff (rst) drive.boost_on |-> drive.isolation_switch_on)
        else $error("boost on with switch off");
    chk_sink_needs_enable: assert property (@(posedge clk_sys)
        disable iff (rst) drive.rail_sink_on |-> $past(sinks_ok))
        else $error("sink without enable");
    chk_discharge_stages_off: assert property (@(posedge clk_sys)
        disable iff (rst) $past(state == SDBC_DIS_SINK) |-> !drive.buck_on
        && !drive.efuse_on && !drive.isolation_switch_on)
        else $error("stage on during discharge");
    chk_fault_irq_low: assert property (@(posedge clk_sys)
        disable iff (rst) sense.overcurrent |=> !interrupt_out_n)
        else $error("interrupt not asserted");
    chk_trip_turns_off: assert property (@(posedge clk_sys)
        disable iff (rst) state == SDBC_ON && sense.overcurrent
        |=> s_trip_hiccup ##1 s_switch_dropped)
        else $error("switch not tripped");
    chk_hiccup_efuse_on: assert property (@(posedge clk_sys)
        disable iff (rst) $past(state == SDBC_HICCUP)
        && state == SDBC_HICCUP |-> drive.efuse_on)
        else $error("efuse off in hiccup");
    chk_supp_buck_on: assert property (@(posedge clk_sys)
        disable iff (rst) state == SDBC_SUPP
        && $past(state == SDBC_SUPP) |-> drive.buck_on)
        else $error("buck off in supplement");
    chk_full_on_limit: assert property (@(posedge clk_sys)
        disable iff (rst) $past(state == SDBC_ON)
        && state == SDBC_ON |-> drive.limit_2a)
        else $error("limit not set");
endmodule // sdbc_core

// ---- rtl/sdbc_pkg.sv ----
// Package for the storage discharge and isolation switch control block
package sdbc_pkg;
    // Register offsets
    localparam logic [7:0] SDBC_REG_DISCHARGE_CONFIG = 8'h2A;
    localparam logic [7:0] SDBC_REG_ISO_OPTIONS = 8'h34;
    localparam logic [7:0] SDBC_REG_DIS_SW_CONTROL = 8'hEB;
    // Field positions
    localparam int SDBC_BIT_AUTO_SINK = 4;
    localparam int SDBC_BIT_RETRY_ONCE = 0;
    localparam int SDBC_BIT_MANUAL = 1;
    localparam int SDBC_BIT_SWITCH_ON = 0;
    localparam int SDBC_BIT_DISCHARGE_ALL = 1;
    localparam int SDBC_BIT_GPIO_DIS_EN = 2;
    localparam int SDBC_BIT_DONE = 3;
    // Reset values
    localparam logic [7:0] SDBC_RST_DISCHARGE_CONFIG = 8'h00;
    localparam logic [7:0] SDBC_RST_ISO_OPTIONS = 8'h00;
    localparam logic [7:0] SDBC_RST_DIS_SW_CONTROL = 8'h00;
    // Timebase: one tick per millisecond at 250 MHz
    localparam int SDBC_CLK_KHZ = 250000;
    localparam int SDBC_TICK_MS = 1;
    localparam int SDBC_TICK_CYCLES = SDBC_CLK_KHZ * SDBC_TICK_MS;
    localparam int SDBC_RETRY_MS = 250;
    localparam int SDBC_RETRY_TICKS = SDBC_RETRY_MS / SDBC_TICK_MS;
    // Threshold base in tenths of a percent
    localparam logic [9:0] SDBC_PG_BASE_LO = 10'h389;
    localparam logic [9:0] SDBC_PG_BASE_HI = 10'h3B1;
    localparam logic [9:0] SDBC_PG_STEP = 10'h005;

    typedef enum {
        SDBC_POR, SDBC_SOFT, SDBC_ON, SDBC_HICCUP, SDBC_SUPP,
        SDBC_SUPP_DIS, SDBC_DIS_STOP, SDBC_DIS_OPEN, SDBC_DIS_SINK,
        SDBC_FORCED
    } sdbc_state_t;

    // Power stage enables grouped together
    typedef struct packed {
        logic efuse_on;
        logic buck_on;
        logic boost_on;
        logic isolation_switch_on;
        logic rail_sink_on;
        logic soft_current;
        logic limit_2a;
    } sdbc_drive_t;

    // Analog comparator results
    typedef struct packed {
        logic vin_ok;
        logic bus_ok;
        logic str_ok;
        logic power_fail;
        logic switch_settled;
        logic storage_at_vin;
        logic overcurrent;
        logic sink_below_10ma;
        logic forced_shutdown;
    } sdbc_sense_t;
endpackage

// ---- tb/sdbc_core_tb.sv ----
// Self-checking bench for the storage discharge and switch controller
`timescale 1ns/1ps
module sdbc_core_tb;
    import sdbc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic discharge_pin_n = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [9:0] storage_pct = 10'h000;
    sdbc_sense_t sense = '0;
    sdbc_drive_t drive;
    logic storage_pg;
    logic split_node_fault;
    logic interrupt_out_n;
    logic look = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int kind_q[$];
    logic [7:0] exp_q[$];

    // Short timebase keeps the retry spans to a few dozen cycles
    sdbc_core #(.TICK_CYCLES(4), .RETRY_TICKS(6)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sense(sense), .storage_pct(storage_pct),
        .discharge_pin_n(discharge_pin_n), .drive(drive),
        .storage_pg(storage_pg), .split_node_fault(split_node_fault),
        .interrupt_out_n(interrupt_out_n)
    );

    function automatic logic [7:0] obs(int k);
        case (k)
            0: return reg_rdata;
            1: return {1'b0, drive};
            2: return {7'h00, storage_pg};
            3: return {6'h00, split_node_fault, interrupt_out_n};
            4: return {7'h00, drive.efuse_on};
            5: return {7'h00, drive.isolation_switch_on};
            6: return {7'h00, drive.soft_current};
            7: return {7'h00, drive.boost_on};
            default: return {7'h00, drive.limit_2a};
        endcase
    endfunction

    // Sampled mid-cycle so every registered output has settled
    always @(negedge clk_sys) begin
        int k;
        logic [7:0] e;
        if (look === 1'b1) begin
            k = kind_q.pop_front();
            e = exp_q.pop_front();
            tests_run++;
            if (obs(k) !== e) begin
                error_cnt++;
                $display("unexpected at %0t: got %h want %h", $time, obs(k), e);
            end
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(int k, logic [7:0] e);
        @(posedge clk_sys);
        kind_q.push_back(k);
        exp_q.push_back(e);
        look <= 1'b1;
        @(posedge clk_sys);
        look <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        chk(0, e);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        results();
    end

    initial begin
        int thr;
        void'($urandom(32'hB240));
        tick(3);
        rst <= 1'b0;
        rd(SDBC_REG_DISCHARGE_CONFIG, SDBC_RST_DISCHARGE_CONFIG);
        rd(SDBC_REG_ISO_OPTIONS, SDBC_RST_ISO_OPTIONS);
        rd(SDBC_REG_DIS_SW_CONTROL, SDBC_RST_DIS_SW_CONTROL);
        rd(8'h55, 8'h00);
        chk(1, 8'h00);
        chk(3, 8'h01);
        $display("test reset finished");
        for (int c = 0; c < 16; c++) begin
            thr = (c[3] ? 945 : 905) + 5 * c[2:0];
            wr(SDBC_REG_DISCHARGE_CONFIG, 8'(c));
            storage_pct <= 10'(thr + $urandom_range(1, 40));
            tick(2);
            chk(2, 8'h01);
            storage_pct <= 10'(thr);
            tick(2);
            chk(2, 8'h00);
        end
        $display("test threshold finished");
        sense.vin_ok <= 1'b1;
        sense.bus_ok <= 1'b1;
        sense.str_ok <= 1'b1;
        tick(4);
        chk(6, 8'h01);
        sense.switch_settled <= 1'b1;
        sense.storage_at_vin <= 1'b1;
        tick(6);
        chk(5, 8'h01);
        chk(8, 8'h01);
        wr(SDBC_REG_ISO_OPTIONS, 8'h02);
        wr(SDBC_REG_DIS_SW_CONTROL, 8'h00);
        tick(2);
        chk(5, 8'h00);
        chk(7, 8'h00);
        wr(SDBC_REG_DIS_SW_CONTROL, 8'h01);
        tick(2);
        chk(5, 8'h01);
        wr(SDBC_REG_ISO_OPTIONS, 8'h00);
        $display("test startup finished");
        sense.overcurrent <= 1'b1;
        tick(3);
        chk(5, 8'h00);
        chk(3, 8'h02);
        chk(4, 8'h01);
        sense.overcurrent <= 1'b0;
        wr(SDBC_REG_ISO_OPTIONS, 8'h80);
        tick(2);
        chk(3, 8'h01);
        chk(5, 8'h00);
        tick(40);
        chk(5, 8'h01);
        $display("test overcurrent finished");
        // Discharge is started from the supplement state
        sense.power_fail <= 1'b1;
        tick(3);
        chk(1, 8'h28);
        sense.power_fail <= 1'b0;
        wr(SDBC_REG_DISCHARGE_CONFIG, 8'h10);
        wr(SDBC_REG_DIS_SW_CONTROL, 8'h02);
        tick(6);
        chk(1, 8'h04);
        sense.bus_ok <= 1'b0;
        sense.sink_below_10ma <= 1'b1;
        tick(4);
        chk(1, 8'h04);
        sense.str_ok <= 1'b0;
        tick(6);
        rd(SDBC_REG_DIS_SW_CONTROL, 8'h08);
        wr(SDBC_REG_DIS_SW_CONTROL, 8'h08);
        sense.bus_ok <= 1'b1;
        sense.str_ok <= 1'b1;
        tick(12);
        chk(5, 8'h01);
        $display("test register discharge finished");
        wr(SDBC_REG_DISCHARGE_CONFIG, 8'h00);
        wr(SDBC_REG_DIS_SW_CONTROL, 8'h04);
        discharge_pin_n <= 1'b0;
        tick(6);
        chk(1, 8'h00);
        sense.bus_ok <= 1'b0;
        tick(6);
        discharge_pin_n <= 1'b1;
        sense.switch_settled <= 1'b0;
        sense.storage_at_vin <= 1'b0;
        wr(SDBC_REG_DIS_SW_CONTROL, 8'h08);
        wr(SDBC_REG_ISO_OPTIONS, 8'h01);
        sense.bus_ok <= 1'b1;
        tick(80);
        chk(6, 8'h00);
        chk(5, 8'h00);
        chk(4, 8'h01);
        $display("test pin discharge and retry finished");
        wr(SDBC_REG_DISCHARGE_CONFIG, 8'h10);
        sense.vin_ok <= 1'b0;
        tick(4);
        chk(1, 8'h04);
        sense.vin_ok <= 1'b1;
        sense.forced_shutdown <= 1'b1;
        tick(3);
        chk(1, 8'h04);
        sense.forced_shutdown <= 1'b0;
        tick(4);
        chk(1, 8'h04);
        $display("test reset sink and forced off finished");
        results();
    end
endmodule // sdbc_core_tb
